// ---- test_vdm_monitor.sv ----
// Purpose: self-checking bench for the valve diagnostic monitor
// Assumes: short waiting step of 8 cycles per ms
// Notes:   checks read outputs just after an edge, pre-update
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
$display("Error t=%0t got %h exp %h", $time, (g), (e)); end end
module test_vdm_monitor;
   localparam int unsigned STEP = 8;
   logic                clk_i = 1'b0;
   logic                rst_i = 1'b1;
   logic                cyc = 1'b0;
   logic                stb = 1'b0;
   logic                we = 1'b0;
   logic [7:0]          adr = 8'h00;
   logic [31:0]         wdat = 32'h0;
   logic [31:0]         rd;
   wire logic           ack;
   wire logic [31:0]    rdat;
   vdm_pkg::vdm_meas_s  meas;
   vdm_pkg::vdm_count_s cnt;
   vdm_pkg::vdm_event_s evt;
   vdm_pkg::vdm_crit_s  crit;
   vdm_pkg::vdm_minor_s minor;
   vdm_pkg::vdm_valve_s valve;
   int                  mismatches = 0;
   int                  compares = 0;
   always #10 clk_i = ~clk_i;
   vdm_monitor #(.WAIT_STEP_CYCLES(STEP)) dut (.clk_i(clk_i), .rst_i(rst_i),
      .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_ack_o(ack),
      .wb_dat_o(rdat), .meas_i(meas), .count_i(cnt), .event_i(evt),
      .crit_status_o(crit), .minor_status_o(minor), .valve_status_o(valve));
   vdm_field fld (.clk_i(clk_i), .meas_o(meas), .count_o(cnt),
      .event_o(evt));
   // classic cycle; returns at the edge that sampled ack
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk_i);
      while (ack !== 1'b1);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task rdchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask
   task wt(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task stop_test;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // hang guard, well past the test length
   initial
   begin
      #200us;
      mismatches++;
      stop_test();
   end
   initial
   begin
      wt(8);
      rst_i <= 1'b0;
      rdchk(8'h04, 32'h0);
      bus(1'b1, 8'hfc, 32'hffff_ffff);
      rdchk(8'hfc, 32'h0);
      $display("registers done");
      bus(1'b1, 8'h04, 32'h0000_00ff);
      bus(1'b1, 8'h08, 32'h00fa_0096);
      fld.sample(16'd100, 16'd200, 1'b0);
      fld.sample(16'd200, 16'd300, 1'b0);
      wt(3);
      `CHK(valve.speed_up, 1'b1)
      `CHK(valve.speed_dn, 1'b1)
      rdchk(8'h30, 32'h0);
      bus(1'b1, 8'h00, 32'h1);
      rdchk(8'h30, 32'h012c_00c8);
      `CHK(valve.speed_window, 1'b1)
      bus(1'b1, 8'h00, 32'h2);
      rdchk(8'h30, 32'h0);
      `CHK(valve.speed_window, 1'b0)
      fld.sample(16'd10, 16'd10, 1'b1);
      wt(3);
      `CHK(valve.speed_up, 1'b0)
      rdchk(8'h34, 32'h000a_000a);
      $display("speed done");
      bus(1'b1, 8'h0c, 32'h0064_0064);
      bus(1'b1, 8'h10, 32'h2);
      fld.meas_o.travel_pct <= 16'sd5000;
      fld.meas_o.input_pct <= 16'sd4800;
      wt(5);
      `CHK(valve.dev_pos, 1'b0)
      wt(20);
      `CHK(valve.dev_pos, 1'b1)
      rdchk(8'h38, 32'd200);
      fld.meas_o.input_pct <= 16'sd5200;
      wt(25);
      `CHK({valve.dev_pos, valve.dev_neg}, 2'b01)
      bus(1'b1, 8'h04, 32'h0000_003f);
      wt(3);
      `CHK(valve.dev_neg, 1'b0)
      fld.meas_o.input_pct <= 16'sd5000;
      bus(1'b1, 8'h04, 32'h0000_00ff);
      bus(1'b1, 8'h14, 32'hff9c_01f4);
      fld.meas_o.temperature <= 16'sd600;
      wt(4);
      `CHK({valve.temp_high, valve.temp_low}, 2'b10)
      fld.meas_o.temperature <= -16'sd200;
      wt(4);
      `CHK({valve.temp_high, valve.temp_low}, 2'b01)
      $display("timed alarms done");
      bus(1'b1, 8'h1c, 32'd10);
      bus(1'b1, 8'h2c, 32'd5);
      fld.count_o.stick_slip <= 32'd11;
      fld.meas_o.zero_angle_now <= 16'sd20;
      fld.meas_o.zero_angle_init <= 16'sd10;
      wt(3);
      `CHK(valve[5:0], 6'h09)
      `CHK({valve.zero_err_dn, valve.zero_err_up}, 2'b01)
      fld.meas_o.loop_current <= 16'sd380;
      fld.meas_o.temperature <= 16'sd851;
      fld.meas_o.pilot_drive <= 16'sd2000;
      fld.event_o <= 12'hffe;
      wt(3);
      `CHK(minor, 10'h1ff)
      `CHK(crit, 3'h7)
      fld.meas_o.loop_current <= 16'sd381;
      fld.meas_o.temperature <= -16'sd450;
      fld.meas_o.pilot_drive <= 16'sd7500;
      fld.event_o <= 12'h000;
      wt(3);
      `CHK(minor, 10'h000)
      fld.pulse_reset();
      wt(3);
      `CHK(minor, 10'h200)
      bus(1'b1, 8'h00, 32'h4);
      wt(2);
      `CHK(minor, 10'h000)
      $display("status done");
      stop_test();
   end
endmodule
`default_nettype wire

// ---- vdm_checker.sv ----
// Purpose: port-level assertions for the valve diagnostic monitor
// Assumes: one clock domain
// Notes:   bound onto vdm_monitor below
`timescale 1ns/1ps
`default_nettype none
module vdm_checker (
   input wire logic               clk_i,
   input wire logic               rst_i,
   input wire logic               ce_i,
   input wire logic               wb_cyc_i,
   input wire logic               wb_stb_i,
   input wire logic               wb_ack_o,
   input wire vdm_pkg::vdm_meas_s  meas_i,
   input wire vdm_pkg::vdm_event_s event_i,
   input wire vdm_pkg::vdm_crit_s  crit_status_o,
   input wire vdm_pkg::vdm_minor_s minor_status_o,
   input wire vdm_pkg::vdm_valve_s valve_status_o
);
   // frozen cycles hold still and are not judged
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i || !ce_i);
   // shared steps
   sequence s_ack_pulse; wb_ack_o ##1 !wb_ack_o; endsequence
   sequence s_dev_drop; ##2 !valve_status_o.dev_pos; endsequence
   property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> s_ack_pulse;
   endproperty
   property p_crit; !$past(rst_i) |-> crit_status_o == {$past(
      event_i.rom_fault), $past(event_i.ram_fault), $past(|event_i[11:9])};
   endproperty
   property p_low; !$past(rst_i) |-> minor_status_o.low_loop_current_flag
      == $past(meas_i.loop_current <= vdm_pkg::LOW_LOOP_CURRENT_10UA);
   endproperty
   property p_hot; !$past(rst_i) |-> minor_status_o.over_temp == $past(
      meas_i.temperature < vdm_pkg::OVER_TEMP_LOW_DC ||
      meas_i.temperature > vdm_pkg::OVER_TEMP_HIGH_DC);
   endproperty
   property p_pilot; !$past(rst_i) |-> minor_status_o.pilot_drive_range_flag
      == $past(meas_i.pilot_drive < vdm_pkg::PILOT_DRIVE_MIN ||
      meas_i.pilot_drive > vdm_pkg::PILOT_DRIVE_MAX);
   endproperty
   // mode flags follow their events one cycle late
   property p_modes; !$past(rst_i) |-> {minor_status_o[8:4],
      minor_status_o[2]} == $past({event_i[2], event_i[3], event_i[4],
      event_i[5], event_i[6], event_i[1]});
   endproperty
   property p_sreset; event_i.settings_reset |=> minor_status_o[9];
   endproperty
   property p_dev_rise; $rose(valve_status_o.dev_pos) |->
      $past(meas_i.travel_pct > meas_i.input_pct, 2);
   endproperty
   property p_neg_rise; $rose(valve_status_o.dev_neg) |->
      $past(meas_i.travel_pct < meas_i.input_pct, 2);
   endproperty
   property p_dev_clear; meas_i.travel_pct <= meas_i.input_pct |->
      s_dev_drop;
   endproperty
   a_ack: assert property (p_ack) else $error("bus ack not a pulse");
   a_crit: assert property (p_crit) else $error("crit bits wrong");
   a_low: assert property (p_low) else $error("low current wrong");
   a_hot: assert property (p_hot) else $error("over temp wrong");
   a_pilot: assert property (p_pilot) else $error("pilot range");
   a_modes: assert property (p_modes) else $error("mode flags");
   a_sreset: assert property (p_sreset) else $error("reset flag");
   a_dev_rise: assert property (p_dev_rise) else $error("dev+ early");
   a_neg_rise: assert property (p_neg_rise) else $error("dev- sign");
   a_dev_clear: assert property (p_dev_clear) else $error("dev+ held");
endmodule
bind vdm_monitor vdm_checker u_chk (.clk_i, .rst_i, .ce_i, .wb_cyc_i,
   .wb_stb_i, .wb_ack_o, .meas_i, .event_i, .crit_status_o,
   .minor_status_o, .valve_status_o);
`default_nettype wire

// ---- vdm_field.sv ----
// Purpose: model of the valve, sensors and mode events feeding the monitor
// Assumes: readings change right after a rising edge
// Notes:   bench sets levels, tasks give strobes
`timescale 1ns/1ps
`default_nettype none
module vdm_field (
   input  wire logic              clk_i,
   output var vdm_pkg::vdm_meas_s  meas_o,
   output var vdm_pkg::vdm_count_s count_o,
   output var vdm_pkg::vdm_event_s event_o
);
   // healthy valve at power-up: 8 mA loop, 50 % pilot drive
   initial
   begin
      meas_o = '0;
      meas_o.loop_current = 16'sh0320;
      meas_o.pilot_drive = 16'sh1388;
      count_o = '0;
      event_o = '0;
   end
   // one speed sample, optionally opening a new day
   task sample(input logic [15:0] up, input logic [15:0] dn, input logic d);
      @(posedge clk_i);
      meas_o.speed_up <= up;
      meas_o.speed_dn <= dn;
      meas_o.speed_valid <= 1'b1;
      meas_o.day_tick <= d;
      @(posedge clk_i);
      meas_o.speed_valid <= 1'b0;
      meas_o.day_tick <= 1'b0;
      meas_o.speed_up <= ~up;
   endtask
   // one-cycle settings-reset report
   task pulse_reset;
      @(posedge clk_i);
      event_o.settings_reset <= 1'b1;
      @(posedge clk_i);
      event_o.settings_reset <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- vdm_monitor.sv ----
// Purpose: valve diagnostic alarm and status monitor, wishbone slave
// Assumes: measurements and events synchronous to clk_i, updated by firmware
// Notes:   alarms read as live levels; only the settings-reset flag is sticky
//
// What this block does
// - keep up and down peak speeds; update command copies the day's top speeds
// - clear command erases both stored peak speeds
// - window alarm when a stored peak lies beyond its programmed threshold
// - separate up and down alarms when the day's top speed exceeds threshold
// - deviation alarm only after threshold exceeded and waiting time elapsed
// - deviation is travel minus input; plus and minus bits, own thresholds
// - every alarm has an enable; disabled alarms never assert
// - temperature alarm when beyond high or low limit past waiting time
// - separate high and low temperature alarm flags
// - critical bits for angle sensor, working memory and program memory
// - low loop current flag at 3.80 mA or less
// - over-temperature flag below -45 C or above +85 C
// - flag when pilot drive is outside its normal range
// - flags while simulations, loop test, step test or auto setup run
// - flag while the valve is forced fully open or closed
// - flag after adjustment and setting data returned to initial values
// - valve status bits read ON when triggered, OFF otherwise
// - stick-slip, stroke, cycle and closure alarms when count exceeds limit
// - up and down zero-point error flags from current versus initial angle
//
// The placing of the registers and the Wishbone register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module vdm_monitor #(
   parameter int unsigned WAIT_STEP_CYCLES = vdm_pkg::WAIT_STEP_CYC
) (
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire logic                ce_i,
   input  wire logic                wb_cyc_i,
   input  wire logic                wb_stb_i,
   input  wire logic                wb_we_i,
   input  wire logic [7:0]          wb_adr_i,
   input  wire logic [3:0]          wb_sel_i,
   input  wire logic [31:0]         wb_dat_i,
   output logic                     wb_ack_o,
   output logic [31:0]              wb_dat_o,
   input  wire vdm_pkg::vdm_meas_s  meas_i,
   input  wire vdm_pkg::vdm_count_s count_i,
   input  wire vdm_pkg::vdm_event_s event_i,
   output vdm_pkg::vdm_crit_s       crit_status_o,
   output vdm_pkg::vdm_minor_s      minor_status_o,
   output vdm_pkg::vdm_valve_s      valve_status_o
);

   // byte-lane merge, shared by every configuration word
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++)
      begin
         if (sel[b])
         begin
            res[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return res;
   endfunction

   logic [31:0]        cfg_reg [vdm_pkg::CFG_WORDS];
   logic [15:0]        peak_up_reg;
   logic [15:0]        peak_dn_reg;
   logic [15:0]        day_up_reg;
   logic [15:0]        day_dn_reg;
   logic [15:0]        step_cnt_reg;
   logic               step_tick_reg;
   logic [15:0]        wait_cnt_reg [vdm_pkg::TCH_NUM];
   logic               timed_reg [vdm_pkg::TCH_NUM];
   logic               reset_seen_reg;
   logic [31:0]        rd_next;
   logic               bus_req;
   logic               wr_take;
   logic [7:0]         cfg_ofs;
   logic [3:0]         cfg_idx;
   logic               cfg_hit;
   logic [7:0]         en;
   logic signed [16:0] dev_val;
   logic signed [16:0] zero_diff;
   logic               tch_cond [vdm_pkg::TCH_NUM];
   logic [15:0]        tch_wait [vdm_pkg::TCH_NUM];
   logic               tch_en [vdm_pkg::TCH_NUM];
   logic               cmd_update;
   logic               cmd_clear;
   logic               cmd_clr_reset;

   // writes land on the edge that samples ack
   assign bus_req  = wb_cyc_i & wb_stb_i;
   assign wr_take  = bus_req & wb_we_i & wb_ack_o;
   assign cfg_ofs  = wb_adr_i - vdm_pkg::OFS_CFG_BASE;
   assign cfg_idx  = cfg_ofs[5:2];
   assign cfg_hit  = (wb_adr_i >= vdm_pkg::OFS_CFG_BASE)
                   & (wb_adr_i < vdm_pkg::OFS_PEAK)
                   & (wb_adr_i[1:0] == 2'h0);
   assign cmd_update    = wr_take & (wb_adr_i == vdm_pkg::OFS_CMD)
                        & wb_sel_i[0] & wb_dat_i[vdm_pkg::CMD_UPDATE_PEAK];
   assign cmd_clear     = wr_take & (wb_adr_i == vdm_pkg::OFS_CMD)
                        & wb_sel_i[0] & wb_dat_i[vdm_pkg::CMD_CLEAR_PEAK];
   assign cmd_clr_reset = wr_take & (wb_adr_i == vdm_pkg::OFS_CMD)
                        & wb_sel_i[0] & wb_dat_i[vdm_pkg::CMD_CLEAR_RESET];
   assign en = cfg_reg[vdm_pkg::CFG_ENABLE][7:0];

   // ack one cycle after the request, for one cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else if (ce_i)
      begin
         wb_ack_o <= bus_req & ~wb_ack_o;
         if (bus_req & ~wb_ack_o)
         begin
            wb_dat_o <= rd_next;
         end
      end
   end

   // configuration words
   generate
      for (genvar g = 0; g < vdm_pkg::CFG_WORDS; g++)
      begin : g_cfg
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               cfg_reg[g] <= vdm_pkg::CFG_RESET;
            end
            else if (ce_i & wr_take & cfg_hit & (cfg_idx == 4'(g)))
            begin
               cfg_reg[g] <= lane_merge(cfg_reg[g], wb_dat_i, wb_sel_i);
            end
         end
      end
   endgenerate

   // read mux; unmapped words answer zero
   always_comb
   begin
      rd_next = 32'h0000_0000;
      if (cfg_hit)
      begin
         rd_next = cfg_reg[cfg_idx];
      end
      else
      begin
         case (wb_adr_i)
            vdm_pkg::OFS_PEAK:    rd_next = {peak_dn_reg, peak_up_reg};
            vdm_pkg::OFS_DAY_MAX: rd_next = {day_dn_reg, day_up_reg};
            vdm_pkg::OFS_DEV:     rd_next = 32'(dev_val);
            vdm_pkg::OFS_CRIT:    rd_next = 32'(crit_status_o);
            vdm_pkg::OFS_MINOR:   rd_next = 32'(minor_status_o);
            vdm_pkg::OFS_VALVE:   rd_next = 32'(valve_status_o);
            default:              rd_next = 32'h0000_0000;
         endcase
      end
   end

   // daily top speed per direction, restarted on the day tick
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         day_up_reg <= 16'h0000;
         day_dn_reg <= 16'h0000;
      end
      else if (ce_i)
      begin
         if (meas_i.day_tick)
         begin
            // a sample in the boundary cycle opens the new day
            day_up_reg <= meas_i.speed_valid ? meas_i.speed_up : 16'h0000;
            day_dn_reg <= meas_i.speed_valid ? meas_i.speed_dn : 16'h0000;
         end
         else if (meas_i.speed_valid)
         begin
            if (meas_i.speed_up > day_up_reg)
            begin
               day_up_reg <= meas_i.speed_up;
            end
            if (meas_i.speed_dn > day_dn_reg)
            begin
               day_dn_reg <= meas_i.speed_dn;
            end
         end
      end
   end

   // stored peaks; clear beats update when both are written
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         peak_up_reg <= 16'h0000;
         peak_dn_reg <= 16'h0000;
      end
      else if (ce_i)
      begin
         if (cmd_clear)
         begin
            peak_up_reg <= 16'h0000;
            peak_dn_reg <= 16'h0000;
         end
         else if (cmd_update)
         begin
            peak_up_reg <= day_up_reg;
            peak_dn_reg <= day_dn_reg;
         end
      end
   end

   // deviation and zero-point difference, both signed
   assign dev_val   = 17'(meas_i.travel_pct) - 17'(meas_i.input_pct);
   assign zero_diff = 17'(meas_i.zero_angle_now)
                    - 17'(meas_i.zero_angle_init);

   // timed channel conditions, deviation thresholds taken as magnitudes, temperature limits signed
   always_comb
   begin
      tch_cond[vdm_pkg::TCH_DEV_POS] = dev_val >
         $signed({1'b0, cfg_reg[vdm_pkg::CFG_DEV_THR][15:0]});
      tch_cond[vdm_pkg::TCH_DEV_NEG] = dev_val <
         -$signed({1'b0, cfg_reg[vdm_pkg::CFG_DEV_THR][31:16]});
      tch_cond[vdm_pkg::TCH_TEMP_HI] = meas_i.temperature >
         $signed(cfg_reg[vdm_pkg::CFG_TEMP_THR][15:0]);
      tch_cond[vdm_pkg::TCH_TEMP_LO] = meas_i.temperature <
         $signed(cfg_reg[vdm_pkg::CFG_TEMP_THR][31:16]);
      tch_wait[vdm_pkg::TCH_DEV_POS] = cfg_reg[vdm_pkg::CFG_DEV_WAIT][15:0];
      tch_wait[vdm_pkg::TCH_DEV_NEG] = cfg_reg[vdm_pkg::CFG_DEV_WAIT][15:0];
      tch_wait[vdm_pkg::TCH_TEMP_HI] = cfg_reg[vdm_pkg::CFG_TEMP_WAIT][15:0];
      tch_wait[vdm_pkg::TCH_TEMP_LO] = cfg_reg[vdm_pkg::CFG_TEMP_WAIT][15:0];
      tch_en[vdm_pkg::TCH_DEV_POS]   = en[vdm_pkg::EN_DEV];
      tch_en[vdm_pkg::TCH_DEV_NEG]   = en[vdm_pkg::EN_DEV];
      tch_en[vdm_pkg::TCH_TEMP_HI]   = en[vdm_pkg::EN_TEMP];
      tch_en[vdm_pkg::TCH_TEMP_LO]   = en[vdm_pkg::EN_TEMP];
   end

   // 1 ms step shared by all waiting counters
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         step_cnt_reg  <= 16'h0000;
         step_tick_reg <= 1'b0;
      end
      else if (ce_i)
      begin
         step_tick_reg <= (step_cnt_reg == 16'(WAIT_STEP_CYCLES - 1));
         if (step_cnt_reg == 16'(WAIT_STEP_CYCLES - 1))
         begin
            step_cnt_reg <= 16'h0000;
         end
         else
         begin
            step_cnt_reg <= step_cnt_reg + 16'h0001;
         end
      end
   end

   // waiting counters: wait resolution is one step, first step may be short
   generate
      for (genvar t = 0; t < vdm_pkg::TCH_NUM; t++)
      begin : g_wait
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               wait_cnt_reg[t] <= 16'h0000;
               timed_reg[t]    <= 1'b0;
            end
            else if (ce_i)
            begin
               if (~tch_cond[t] | ~tch_en[t])
               begin
                  wait_cnt_reg[t] <= 16'h0000;
               end
               else if (step_tick_reg & (wait_cnt_reg[t] != 16'hffff))
               begin
                  wait_cnt_reg[t] <= wait_cnt_reg[t] + 16'h0001;
               end
               timed_reg[t] <= tch_en[t] & tch_cond[t]
                             & (wait_cnt_reg[t] >= tch_wait[t]);
            end
         end
      end
   endgenerate

   // valve status, live levels gated by enables
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         valve_status_o <= '0;
      end
      else if (ce_i)
      begin
         valve_status_o.stick_slip    <= en[vdm_pkg::EN_STICK]
            & (count_i.stick_slip > cfg_reg[vdm_pkg::CFG_SS_THR]);
         valve_status_o.total_stroke  <= en[vdm_pkg::EN_STROKE]
            & (count_i.total_stroke > cfg_reg[vdm_pkg::CFG_STROKE_THR]);
         valve_status_o.cycle_count   <= en[vdm_pkg::EN_CYCLE]
            & (count_i.cycle_count > cfg_reg[vdm_pkg::CFG_CYCLE_THR]);
         valve_status_o.shutoff_count <= en[vdm_pkg::EN_SHUT]
            & (count_i.shutoff_count > cfg_reg[vdm_pkg::CFG_SHUT_THR]);
         valve_status_o.zero_err_up   <= en[vdm_pkg::EN_ZERO] & (zero_diff >
            $signed({1'b0, cfg_reg[vdm_pkg::CFG_ZERO_THR][15:0]}));
         valve_status_o.zero_err_dn   <= en[vdm_pkg::EN_ZERO] & (zero_diff <
            -$signed({1'b0, cfg_reg[vdm_pkg::CFG_ZERO_THR][31:16]}));
         valve_status_o.speed_up      <= en[vdm_pkg::EN_SPEED]
            & (day_up_reg > cfg_reg[vdm_pkg::CFG_SPEED_THR][15:0]);
         valve_status_o.speed_dn      <= en[vdm_pkg::EN_SPEED]
            & (day_dn_reg > cfg_reg[vdm_pkg::CFG_SPEED_THR][31:16]);
         valve_status_o.speed_window  <= en[vdm_pkg::EN_SPEED]
            & ((peak_up_reg > cfg_reg[vdm_pkg::CFG_SPEED_THR][15:0])
             | (peak_dn_reg > cfg_reg[vdm_pkg::CFG_SPEED_THR][31:16]));
         valve_status_o.dev_pos   <= timed_reg[vdm_pkg::TCH_DEV_POS];
         valve_status_o.dev_neg   <= timed_reg[vdm_pkg::TCH_DEV_NEG];
         valve_status_o.temp_high <= timed_reg[vdm_pkg::TCH_TEMP_HI];
         valve_status_o.temp_low  <= timed_reg[vdm_pkg::TCH_TEMP_LO];
      end
   end

   // critical failures follow their inputs
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         crit_status_o <= '0;
      end
      else if (ce_i)
      begin
         crit_status_o.angle_sensor_fault_flag <= event_i.lever_detached
            | event_i.angle_out_of_range
            | event_i.connector_detached;
         crit_status_o.ram_fault <= event_i.ram_fault;
         crit_status_o.rom_fault <= event_i.rom_fault;
      end
   end

   // settings-reset memory; a new reset event beats a software clear
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         reset_seen_reg <= 1'b0;
      end
      else if (ce_i)
      begin
         if (event_i.settings_reset)
         begin
            reset_seen_reg <= 1'b1;
         end
         else if (cmd_clr_reset)
         begin
            reset_seen_reg <= 1'b0;
         end
      end
   end

   // minor failures
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         minor_status_o <= '0;
      end
      else if (ce_i)
      begin
         minor_status_o.low_loop_current_flag <= meas_i.loop_current
            <= vdm_pkg::LOW_LOOP_CURRENT_10UA;
         minor_status_o.over_temp <=
            (meas_i.temperature < vdm_pkg::OVER_TEMP_LOW_DC)
          | (meas_i.temperature > vdm_pkg::OVER_TEMP_HIGH_DC);
         minor_status_o.pilot_drive_range_flag <=
            (meas_i.pilot_drive < vdm_pkg::PILOT_DRIVE_MIN)
          | (meas_i.pilot_drive > vdm_pkg::PILOT_DRIVE_MAX);
         minor_status_o.input_sim               <= event_i.input_sim;
         minor_status_o.pilot_drive_forced_flag <=
            event_i.pilot_drive_sim;
         minor_status_o.loop_test  <= event_i.loop_test;
         minor_status_o.step_test  <= event_i.step_test;
         minor_status_o.automatic_setup_flag <=
            event_i.automatic_setup;
         minor_status_o.forced_end_position_flag <=
            event_i.forced_end_position;
         minor_status_o.settings_reset <= reset_seen_reg
            | event_i.settings_reset;
      end
   end

endmodule
`default_nettype wire

// ---- vdm_pkg.sv ----
// Purpose: shared constants and carriers for the valve diagnostic monitor
// Assumes: 50 MHz clock, 32-bit classic wishbone register access
// Notes:   scaled units: 0.01 % travel, 0.1 degC, 10 uA loop current
`default_nettype none
package vdm_pkg;
   // waiting times count in 1 ms steps
   localparam int unsigned CLK_HZ        = 50_000_000;
   localparam int unsigned WAIT_STEP_US  = 1000;
   localparam int unsigned WAIT_STEP_CYC = CLK_HZ / 1_000_000 * WAIT_STEP_US;

   // fixed limits of the minor status flags
   localparam logic signed [15:0] LOW_LOOP_CURRENT_10UA = 16'sh017c; // 3.80 mA
   localparam logic signed [15:0] OVER_TEMP_LOW_DC      = 16'shfe3e; // -45 C
   localparam logic signed [15:0] OVER_TEMP_HIGH_DC     = 16'sh0352; // +85 C
   localparam logic signed [15:0] PILOT_DRIVE_MIN       = 16'sh09c4; // 25 %
   localparam logic signed [15:0] PILOT_DRIVE_MAX       = 16'sh1d4c; // 75 %

   // register byte offsets
   localparam logic [7:0] OFS_CMD      = 8'h00;
   localparam logic [7:0] OFS_CFG_BASE = 8'h04;
   localparam logic [7:0] OFS_PEAK     = 8'h30;
   localparam logic [7:0] OFS_DAY_MAX  = 8'h34;
   localparam logic [7:0] OFS_DEV      = 8'h38;
   localparam logic [7:0] OFS_CRIT     = 8'h3c;
   localparam logic [7:0] OFS_MINOR    = 8'h40;
   localparam logic [7:0] OFS_VALVE    = 8'h44;

   // configuration words from OFS_CFG_BASE
   localparam int CFG_WORDS      = 11;
   localparam int CFG_ENABLE     = 0;
   localparam int CFG_SPEED_THR  = 1;  // [15:0] up, [31:16] down
   localparam int CFG_DEV_THR    = 2;  // [15:0] plus, [31:16] minus
   localparam int CFG_DEV_WAIT   = 3;  // [15:0] ms
   localparam int CFG_TEMP_THR   = 4;  // [15:0] high, [31:16] low
   localparam int CFG_TEMP_WAIT  = 5;  // [15:0] ms
   localparam int CFG_SS_THR     = 6;
   localparam int CFG_STROKE_THR = 7;
   localparam int CFG_CYCLE_THR  = 8;
   localparam int CFG_SHUT_THR   = 9;
   localparam int CFG_ZERO_THR   = 10; // [15:0] up, [31:16] down
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;

   // command word bits
   localparam int CMD_UPDATE_PEAK = 0;
   localparam int CMD_CLEAR_PEAK  = 1;
   localparam int CMD_CLEAR_RESET = 2;

   // alarm enable bits
   localparam int EN_STICK  = 0;
   localparam int EN_STROKE = 1;
   localparam int EN_CYCLE  = 2;
   localparam int EN_ZERO   = 3;
   localparam int EN_SHUT   = 4;
   localparam int EN_SPEED  = 5;
   localparam int EN_DEV    = 6;
   localparam int EN_TEMP   = 7;

   // timed channels
   localparam int TCH_DEV_POS = 0;
   localparam int TCH_DEV_NEG = 1;
   localparam int TCH_TEMP_HI = 2;
   localparam int TCH_TEMP_LO = 3;
   localparam int TCH_NUM     = 4;

   typedef struct packed {
      logic [15:0]        speed_up;
      logic [15:0]        speed_dn;
      logic               speed_valid;
      logic               day_tick;
      logic signed [15:0] travel_pct;
      logic signed [15:0] input_pct;
      logic signed [15:0] temperature;
      logic signed [15:0] loop_current;
      logic signed [15:0] pilot_drive;
      logic signed [15:0] zero_angle_now;
      logic signed [15:0] zero_angle_init;
   } vdm_meas_s;

   typedef struct packed {
      logic [31:0] stick_slip;
      logic [31:0] total_stroke;
      logic [31:0] cycle_count;
      logic [31:0] shutoff_count;
   } vdm_count_s;

   typedef struct packed {
      logic lever_detached;
      logic angle_out_of_range;
      logic connector_detached;
      logic ram_fault;
      logic rom_fault;
      logic input_sim;
      logic pilot_drive_sim;
      logic loop_test;
      logic step_test;
      logic automatic_setup;
      logic forced_end_position;
      logic settings_reset;
   } vdm_event_s;

   typedef struct packed {
      logic rom_fault;
      logic ram_fault;
      logic angle_sensor_fault_flag;
   } vdm_crit_s;

   typedef struct packed {
      logic settings_reset;
      logic automatic_setup_flag;
      logic step_test;
      logic loop_test;
      logic pilot_drive_forced_flag;
      logic input_sim;
      logic over_temp;
      logic forced_end_position_flag;
      logic pilot_drive_range_flag;
      logic low_loop_current_flag;
   } vdm_minor_s;

   typedef struct packed {
      logic temp_low;
      logic temp_high;
      logic dev_neg;
      logic dev_pos;
      logic speed_window;
      logic speed_dn;
      logic speed_up;
      logic shutoff_count;
      logic zero_err_dn;
      logic zero_err_up;
      logic cycle_count;
      logic total_stroke;
      logic stick_slip;
   } vdm_valve_s;
endpackage
`default_nettype wire
